/* File: rtl/shpc_pkg.sv */
// shared constants for the slot hot-plug controller
package shpc_pkg;
	localparam int unsigned NUM_PORTS   = 6;
	localparam int unsigned CLK_HZ      = 20000000;
	// interlock pulse: longer than 100 ms, shorter than 150 ms; aim at 125 ms
	localparam int unsigned ILOCK_MS    = 125;
	localparam int unsigned ILOCK_CYC   = CLK_HZ / 1000 * ILOCK_MS;
	localparam int unsigned PME_TO_CYC  = 200000;
	// register offsets
	localparam logic [7:0] OFS_CAP      = 8'h00;
	localparam logic [7:0] OFS_CTL      = 8'h04;
	localparam logic [7:0] OFS_STS      = 8'h08;
	localparam logic [7:0] OFS_CFG      = 8'h0c;
	localparam logic [7:0] OFS_GPECTL   = 8'h10;
	localparam logic [7:0] OFS_GPESTS   = 8'h14;
	localparam logic [7:0] OFS_PM       = 8'h18;
	localparam logic [7:0] OFS_IN       = 8'h1c;
	// slot capabilities fields
	localparam int unsigned CAP_LATCH   = 2;
	localparam int unsigned CAP_CTRL    = 6;
	localparam int unsigned CAP_EXP     = 7;
	// slot control fields
	localparam int unsigned CTL_ABP     = 0;
	localparam int unsigned CTL_PFD     = 1;
	localparam int unsigned CTL_LSC     = 2;
	localparam int unsigned CTL_PDC     = 3;
	localparam int unsigned CTL_CC      = 4;
	localparam int unsigned CTL_HOTPLUG_IRQ_ENABLE    = 5;
	localparam int unsigned CTL_AIND    = 6;
	localparam int unsigned CTL_PIND    = 8;
	localparam int unsigned CTL_PCC     = 10;
	localparam int unsigned CTL_ILK     = 11;
	// slot status fields
	localparam int unsigned STS_ABP     = 0;
	localparam int unsigned STS_PFD     = 1;
	localparam int unsigned STS_LSC     = 2;
	localparam int unsigned STS_PDC     = 3;
	localparam int unsigned STS_CC      = 4;
	localparam int unsigned STS_LSS     = 5;
	localparam int unsigned STS_PDS     = 6;
	localparam int unsigned STS_ILS     = 7;
	// hot-plug config fields: inversion bits 0..4, modes above
	localparam int unsigned CFG_TOGGLE  = 8;
	localparam int unsigned CFG_LATCHIL = 9;
	localparam int unsigned CFG_AUTOOFF = 10;
	localparam int unsigned CFG_GPIOALT = 11;
	// pm register fields
	localparam int unsigned PM_D3       = 0;
	localparam int unsigned PM_MSIEN    = 1;
	localparam int unsigned PM_LEGACY_IRQ_DISABLE    = 2;
	localparam int unsigned PM_PME_STATUS     = 3;
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;
endpackage

/* File: rtl/shpc_sync.sv */
// two flip-flop level synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module shpc_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         core_clk_in,
	input  wire logic         reset_n_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;   // first stage, read only by second stage

	// ----------------------------------------------------------------
	// synchroniser stages
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
endmodule
`default_nettype wire

/* File: rtl/shpc_timer.sv */
// down counter that reports expiry as a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module shpc_timer #(
	parameter int unsigned CYC = 16
) (
	input  wire logic core_clk_in,
	input  wire logic reset_n_in,
	input  wire logic start_in,     // load and run
	input  wire logic stop_in,      // abandon
	output logic      busy_out,
	output logic      done_out      // pulse at expiry
);
	logic [31:0] cnt_q;

	// ----------------------------------------------------------------
	// count; start wins over stop
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			cnt_q    <= '0;
			done_out <= 1'b0;
		end
		else
		begin
			done_out <= 1'b0;
			if (start_in)
				cnt_q <= 32'(CYC);
			else if (stop_in)
				cnt_q <= '0;
			else if (cnt_q != '0)
			begin
				cnt_q    <= cnt_q - 32'd1;
				done_out <= (cnt_q == 32'd1);
			end
		end
	assign busy_out = (cnt_q != '0);
endmodule
`default_nettype wire

/* File: rtl/shpc_top.sv */
// slot hot-plug controller for six downstream ports
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - port logic runs only with controller present
// - ports one through six, own slot signals
// - slot signals go through the expander ports
// - presence comes only from presence input level
// - per-signal inversion, common to all ports
// - interlock command gives a 125 ms pulse
// - toggle mode inverts interlock instead
// - latch mode: interlock status follows latch input
// - latch mode: latch state reads closed
// - otherwise interlock status shows interlock output
// - latch open cuts power when auto-off enabled and latch capability set
// - eeprom load never sets command completed
// - interrupts only with hotplug irq enable
// - masked-in status events request interrupt
// - msi or intx chosen by command bits
// - d3hot with irq off: wake message only
// - d3hot with irq on: wake and interrupt
// - masked events silent; completion never wakes
// - general event mode replaces irq and wake
// - gpio pin asserts only in alternate mode
// - general status set only in general event mode
// - general mode leaves slot bits working
// - wake message resent if status not cleared
module shpc_top
	import shpc_pkg::*;
#(
	parameter int unsigned PME_TIMEOUT = PME_TO_CYC
) (
	input  wire logic                 core_clk_in,
	input  wire logic                 reset_n_in,
	input  wire logic [7:0]           addr_in,      // byte address in port
	input  wire logic [2:0]           port_sel_in,  // 1..6
	input  wire logic [31:0]          wdata_in,
	input  wire logic                 wr_in,
	input  wire logic                 rd_in,
	output logic      [31:0]          rdata_out,
	input  wire logic                 eeprom_load_in, // defaults loader
	input  wire logic [NUM_PORTS-1:0] attention_button_in,
	input  wire logic [NUM_PORTS-1:0] presence_in,
	input  wire logic [NUM_PORTS-1:0] power_fault_in,
	input  wire logic [NUM_PORTS-1:0] latch_sensor_in,
	input  wire logic [NUM_PORTS-1:0] power_good_in,
	output logic      [NUM_PORTS-1:0] attention_indicator_out,
	output logic      [NUM_PORTS-1:0] power_indicator_out,
	output logic      [NUM_PORTS-1:0] slot_power_enable_out,
	output logic      [NUM_PORTS-1:0] interlock_out,
	output logic      [NUM_PORTS-1:0] slot_reset_out,
	output logic      [NUM_PORTS-1:0] msi_req_out,
	output logic      [NUM_PORTS-1:0] intx_out,
	output logic      [NUM_PORTS-1:0] pme_msg_out,
	output logic                      general_event_output,
	output logic                      gpio7_out,
	output logic                      gpio7_oe_n_out
);
	// ----------------------------------------------------------------
	// synchronised slot inputs
	// ----------------------------------------------------------------
	logic [NUM_PORTS-1:0] ab_s, pd_s, pf_s, ls_s, pg_s;

	shpc_sync #(.W(5*NUM_PORTS)) u_sync (
		.core_clk_in (core_clk_in),
		.reset_n_in  (reset_n_in),
		.async_in    ({attention_button_in, presence_in, power_fault_in,
		               latch_sensor_in, power_good_in}),
		.sync_out    ({ab_s, pd_s, pf_s, ls_s, pg_s})
	);

	// ----------------------------------------------------------------
	// shared registers
	// ----------------------------------------------------------------
	logic [15:0]          cfg_q;        // hotplug_config_control
	logic [NUM_PORTS-1:0] gpectl_q;     // general_event_control
	logic [NUM_PORTS-1:0] gpests_q;     // general_event_status
	logic [NUM_PORTS-1:0] sel_1h;       // decoded port select
	logic [31:0]          rdata_d;
	logic [NUM_PORTS-1:0] gev_req;      // per-port general event
	logic                 wr_shared;

	// one inversion bit per input, applied to every port
	logic [NUM_PORTS-1:0] ab_p, pd_p, pf_p, ls_p, pg_p;
	assign ab_p = ab_s ^ {NUM_PORTS{cfg_q[0]}};
	assign pd_p = pd_s ^ {NUM_PORTS{cfg_q[1]}};
	assign pf_p = pf_s ^ {NUM_PORTS{cfg_q[2]}};
	assign ls_p = ls_s ^ {NUM_PORTS{cfg_q[3]}};  // 1 means open
	assign pg_p = pg_s ^ {NUM_PORTS{cfg_q[4]}};

	assign wr_shared = wr_in && (port_sel_in == 3'd0);

	// ----------------------------------------------------------------
	// shared register writes; general status set wins over clear
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			cfg_q    <= '0;
			gpectl_q <= '0;
		end
		else if (wr_shared)
		begin
			if (addr_in == OFS_CFG)
				cfg_q <= wdata_in[15:0];
			if (addr_in == OFS_GPECTL)
				gpectl_q <= wdata_in[NUM_PORTS-1:0];
		end

	always_ff @(posedge core_clk_in or negedge reset_n_in)
		if (!reset_n_in)
			gpests_q <= '0;
		else if (wr_shared && addr_in == OFS_GPESTS)
			gpests_q <= (gpests_q & ~wdata_in[NUM_PORTS-1:0])
			            | (gev_req & gpectl_q);
		else
			gpests_q <= gpests_q | (gev_req & gpectl_q);

	// general event output is the or of requests from ports in general event mode
	always_ff @(posedge core_clk_in or negedge reset_n_in)
		if (!reset_n_in)
			general_event_output <= 1'b0;
		else
			general_event_output <= |(gev_req & gpectl_q);

	// pin drives only in alternate function
	assign gpio7_out      = general_event_output & cfg_q[CFG_GPIOALT];
	assign gpio7_oe_n_out = ~cfg_q[CFG_GPIOALT];

	// ----------------------------------------------------------------
	// per-port controllers
	// ----------------------------------------------------------------
	logic [31:0] port_rd [NUM_PORTS];

	for (genvar p = 0; p < NUM_PORTS; p++)
	begin : g_port
		logic [7:0]  cap_q;      // slot_capabilities
		logic [15:0] ctl_q;      // slot_control
		logic [4:0]  evt_q;      // sticky slot_status events
		logic [3:0]  pm_q;       // d3, msi enable, intx disable, pme status
		logic        ilk_q;      // interlock level
		logic        pd_q, ls_q, ab_q, pf_q;  // previous levels
		logic        wr_p, controller_present_cap, ilk_start, ilk_done, ilk_busy;
		logic        pme_start, pme_done, pme_busy;
		logic [4:0]  evt_set, unmasked;
		logic        any_irq, any_wake, gev;

		assign sel_1h[p] = (port_sel_in == 3'(p + 1));
		assign wr_p      = wr_in && sel_1h[p];
		assign controller_present_cap       = cap_q[CAP_CTRL];

		// capability and control writes; eeprom load uses same path
		always_ff @(posedge core_clk_in or negedge reset_n_in)
			if (!reset_n_in)
			begin
				cap_q <= '0;
				ctl_q <= '0;
				pm_q  <= '0;
			end
			else
			begin
				if (wr_p && addr_in == OFS_CAP)
					cap_q <= wdata_in[7:0];
				if (wr_p && addr_in == OFS_CTL)
					ctl_q <= wdata_in[15:0];
				if (wr_p && addr_in == OFS_PM)
					pm_q[2:0] <= wdata_in[2:0];
				// pme status: set by wake message, write one to clear
				if (pme_start)
					pm_q[PM_PME_STATUS] <= 1'b1;
				else if (wr_p && addr_in == OFS_PM && wdata_in[PM_PME_STATUS])
					pm_q[PM_PME_STATUS] <= 1'b0;
			end

		// edge detection on conditioned inputs
		always_ff @(posedge core_clk_in or negedge reset_n_in)
			if (!reset_n_in)
			begin
				pd_q <= 1'b0;
				ls_q <= 1'b0;
				ab_q <= 1'b0;
				pf_q <= 1'b0;
			end
			else
			begin
				pd_q <= pd_p[p];
				ls_q <= ls_p[p];
				ab_q <= ab_p[p];
				pf_q <= pf_p[p];
			end

		// command completed follows software writes to control only
		assign evt_set[STS_ABP] = controller_present_cap && ab_p[p] && !ab_q;
		assign evt_set[STS_PFD] = controller_present_cap && pf_p[p] && !pf_q;
		assign evt_set[STS_LSC] = controller_present_cap && (ls_p[p] != ls_q);
		assign evt_set[STS_PDC] = controller_present_cap && (pd_p[p] != pd_q);
		assign evt_set[STS_CC]  = controller_present_cap && wr_p && addr_in == OFS_CTL
		                          && !eeprom_load_in;

		// sticky status, set wins over write-one clear
		always_ff @(posedge core_clk_in or negedge reset_n_in)
			if (!reset_n_in)
				evt_q <= '0;
			else if (wr_p && addr_in == OFS_STS)
				evt_q <= (evt_q & ~wdata_in[4:0]) | evt_set;
			else
				evt_q <= evt_q | evt_set;

		// interlock pulse timer
		assign ilk_start = controller_present_cap && wr_p && addr_in == OFS_CTL
		                   && wdata_in[CTL_ILK] && !cfg_q[CFG_TOGGLE];
		shpc_timer #(.CYC(ILOCK_CYC)) u_ilk (
			.core_clk_in (core_clk_in),
			.reset_n_in  (reset_n_in),
			.start_in    (ilk_start && !ilk_busy),
			.stop_in     (1'b0),
			.busy_out    (ilk_busy),
			.done_out    (ilk_done)
		);

		always_ff @(posedge core_clk_in or negedge reset_n_in)
			if (!reset_n_in)
				ilk_q <= 1'b0;
			else if (controller_present_cap && wr_p && addr_in == OFS_CTL
			         && wdata_in[CTL_ILK] && cfg_q[CFG_TOGGLE])
				ilk_q <= ~ilk_q;
			else if (ilk_start && !ilk_busy)
				ilk_q <= 1'b1;
			else if (ilk_done)
				ilk_q <= 1'b0;

		// slot outputs through the expander port group
		always_ff @(posedge core_clk_in or negedge reset_n_in)
			if (!reset_n_in)
			begin
				attention_indicator_out[p] <= 1'b0;
				power_indicator_out[p]     <= 1'b0;
				slot_power_enable_out[p]   <= 1'b0;
				interlock_out[p]           <= 1'b0;
				slot_reset_out[p]          <= 1'b0;
			end
			else
			begin
				attention_indicator_out[p] <= controller_present_cap && ctl_q[CTL_AIND];
				power_indicator_out[p]     <= controller_present_cap && ctl_q[CTL_PIND];
				slot_power_enable_out[p]   <= controller_present_cap && ctl_q[CTL_PCC]
				    && !(cfg_q[CFG_AUTOOFF] && cap_q[CAP_LATCH]
				         && ls_p[p]);
				interlock_out[p]           <= controller_present_cap && ilk_q;
				slot_reset_out[p]          <= !(controller_present_cap && pg_p[p]);
			end

		// event routing
		assign unmasked = evt_q & ctl_q[4:0];
		assign any_irq  = controller_present_cap && ctl_q[CTL_HOTPLUG_IRQ_ENABLE] && |unmasked;
		assign any_wake = controller_present_cap && pm_q[PM_D3]
		                  && |unmasked[3:0];
		assign gev      = gpectl_q[p];
		assign gev_req[p] = any_irq || any_wake;

		always_ff @(posedge core_clk_in or negedge reset_n_in)
			if (!reset_n_in)
			begin
				msi_req_out[p] <= 1'b0;
				intx_out[p]    <= 1'b0;
			end
			else
			begin
				msi_req_out[p] <= any_irq && !gev && pm_q[PM_MSIEN];
				intx_out[p]    <= any_irq && !gev && !pm_q[PM_MSIEN]
				                  && !pm_q[PM_LEGACY_IRQ_DISABLE];
			end

		// wake message on rise of wake request, resent on timeout
		logic wake_q;
		always_ff @(posedge core_clk_in or negedge reset_n_in)
			if (!reset_n_in)
				wake_q <= 1'b0;
			else
				wake_q <= any_wake && !gev;

		assign pme_start = (any_wake && !gev && !wake_q)
		                   || (pme_done && pm_q[PM_PME_STATUS]);
		shpc_timer #(.CYC(PME_TIMEOUT)) u_pme (
			.core_clk_in (core_clk_in),
			.reset_n_in  (reset_n_in),
			.start_in    (pme_start),
			.stop_in     (!pm_q[PM_PME_STATUS]),
			.busy_out    (pme_busy),
			.done_out    (pme_done)
		);

		always_ff @(posedge core_clk_in or negedge reset_n_in)
			if (!reset_n_in)
				pme_msg_out[p] <= 1'b0;
			else
				pme_msg_out[p] <= pme_start;

		// read view of this port
		always_comb
		begin
			port_rd[p] = RST_WORD;
			unique case (addr_in)
				OFS_CAP: port_rd[p] = {24'h0, cap_q};
				OFS_CTL: port_rd[p] = {16'h0, ctl_q};
				OFS_STS:
				begin
					port_rd[p][4:0]    = evt_q;
					port_rd[p][STS_LSS] = cfg_q[CFG_LATCHIL]
					                      ? 1'b0 : ls_p[p];
					port_rd[p][STS_PDS] = pd_p[p];
					port_rd[p][STS_ILS] = cfg_q[CFG_LATCHIL]
					    ? ls_p[p] : interlock_out[p];
				end
				OFS_PM:  port_rd[p] = {28'h0, pm_q};
				OFS_IN:  port_rd[p] = {26'h0, pme_busy, ab_p[p], pd_p[p],
				                       pf_p[p], ls_p[p], pg_p[p]};
				default: port_rd[p] = RST_WORD;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read mux; unmapped reads return zero
	// ----------------------------------------------------------------
	always_comb
	begin
		rdata_d = RST_WORD;
		if (port_sel_in == 3'd0)
		begin
			if (addr_in == OFS_CFG)
				rdata_d = {16'h0, cfg_q};
			else if (addr_in == OFS_GPECTL)
				rdata_d = {26'h0, gpectl_q};
			else if (addr_in == OFS_GPESTS)
				rdata_d = {26'h0, gpests_q};
		end
		else
			for (int i = 0; i < NUM_PORTS; i++)
				if (sel_1h[i])
					rdata_d = port_rd[i];
	end

	// data appears in the cycle after the read strobe only
	always_ff @(posedge core_clk_in or negedge reset_n_in)
		if (!reset_n_in)
			rdata_out <= RST_WORD;
		else if (rd_in)
			rdata_out <= rdata_d;
		else
			rdata_out <= RST_WORD;
endmodule
`default_nettype wire

/* File: verif/shpc_slot_model.sv */
// slot-side stand-in: sensor levels and a slow power-good answer
`timescale 1ns/1ps
`default_nettype none
module shpc_slot_model
	import shpc_pkg::*;
(
	input  wire logic                 core_clk_in,
	input  wire logic [NUM_PORTS-1:0] power_enable_in,
	output logic      [NUM_PORTS-1:0] button_out,
	output logic      [NUM_PORTS-1:0] presence_out,
	output logic      [NUM_PORTS-1:0] fault_out,
	output logic      [NUM_PORTS-1:0] latch_out,
	output logic      [NUM_PORTS-1:0] power_good_out
);
	logic [3*NUM_PORTS-1:0] ramp_q; // supply settling pipeline
	// --------
	// sensor levels, set by the bench, stand at their last value
	// --------
	initial
	begin
		button_out = '0;
		presence_out = '0;
		fault_out = '0;
		latch_out = '0;
		power_good_out = '0;
		ramp_q = '0;
	end
	// power good trails the enable, as a real supply would
	always @(posedge core_clk_in)
	begin
		ramp_q <= {ramp_q[2*NUM_PORTS-1:0], power_enable_in};
		power_good_out <= ramp_q[3*NUM_PORTS-1:2*NUM_PORTS];
	end
endmodule
`default_nettype wire

/* File: verif/shpc_chk.sv */
// checker: port-one hot-plug behaviour at the controller ports
`timescale 1ns/1ps
`default_nettype none
module shpc_chk
	import shpc_pkg::*;
(
	input wire logic                 core_clk_in,
	input wire logic                 reset_n_in,
	input wire logic [7:0]           addr_in,
	input wire logic [2:0]           port_sel_in,
	input wire logic [31:0]          wdata_in,
	input wire logic                 wr_in,
	input wire logic [NUM_PORTS-1:0] latch_sensor_in,
	input wire logic [NUM_PORTS-1:0] slot_power_enable_out,
	input wire logic [NUM_PORTS-1:0] interlock_out,
	input wire logic [NUM_PORTS-1:0] msi_req_out,
	input wire logic [NUM_PORTS-1:0] intx_out,
	input wire logic [NUM_PORTS-1:0] pme_msg_out,
	input wire logic                 general_event_output,
	input wire logic                 gpio7_out,
	input wire logic                 gpio7_oe_n_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	// --------
	// shadow copies of the registers steering port one
	// --------
	logic [31:0] cap_q, ctl_q, pm_q, cfg_q, gpe_q;
	logic [2:0]  wr_hist_q;  // outputs trail a write by up to three edges
	logic [2:0]  ilk_hist_q; // recent interlock commands
	logic        p1, sh, quiet, ilk_cmd, lat_off;
	assign p1 = wr_in && port_sel_in == 3'h1;
	assign sh = wr_in && port_sel_in == 3'h0;
	assign quiet = wr_hist_q == 3'h0;
	assign ilk_cmd = p1 && addr_in == OFS_CTL && wdata_in[CTL_ILK]
		&& cap_q[CAP_CTRL];
	assign lat_off = (latch_sensor_in[0] ^ cfg_q[3]) && cfg_q[CFG_AUTOOFF]
		&& cap_q[CAP_LATCH] && cap_q[CAP_CTRL];
	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			{cap_q, ctl_q, pm_q, cfg_q, gpe_q} <= '0;
			wr_hist_q <= '0;
			ilk_hist_q <= '0;
		end
		else
		begin
			wr_hist_q <= {wr_hist_q[1:0], wr_in};
			ilk_hist_q <= {ilk_hist_q[1:0], ilk_cmd};
			if (p1 && addr_in == OFS_CAP)
				cap_q <= wdata_in;
			if (p1 && addr_in == OFS_CTL)
				ctl_q <= wdata_in;
			if (p1 && addr_in == OFS_PM)
				pm_q <= wdata_in;
			if (sh && addr_in == OFS_CFG)
				cfg_q <= wdata_in;
			if (sh && addr_in == OFS_GPECTL)
				gpe_q <= wdata_in;
		end
	end
	// --------
	// properties
	// --------
	sequence ilk_up_s;
		##[1:3] interlock_out[0] ##1 interlock_out[0] [*7];
	endsequence
	sequence lat_open_s;
		lat_off [*6];
	endsequence
	AST_ILK_ON: assert property (ilk_cmd && !interlock_out[0] |-> ilk_up_s)
		else $error("interlock did not rise and hold");
	AST_ILK_TOG: assert property (ilk_cmd && cfg_q[CFG_TOGGLE]
		&& interlock_out[0] |-> ##[1:3] !interlock_out[0])
		else $error("interlock toggle did not fall");
	AST_ILK_CAUSE: assert property ($rose(interlock_out[0]) |-> |ilk_hist_q)
		else $error("interlock rose without a command");
	AST_INERT: assert property (quiet && !cap_q[CAP_CTRL] |->
		!(msi_req_out[0] || intx_out[0] || pme_msg_out[0]))
		else $error("port acted without controller present");
	AST_HOTPLUG_IRQ_ENABLE: assert property (quiet && !ctl_q[CTL_HOTPLUG_IRQ_ENABLE] |->
		!msi_req_out[0] && !intx_out[0])
		else $error("interrupt with hotplug irq disabled");
	AST_MSI: assert property (quiet && msi_req_out[0] |-> pm_q[PM_MSIEN])
		else $error("msi without msi enable");
	AST_INTX: assert property (quiet && intx_out[0] |->
		!pm_q[PM_MSIEN] && !pm_q[PM_LEGACY_IRQ_DISABLE])
		else $error("intx while msi on or intx disabled");
	AST_PME: assert property (quiet && pme_msg_out[0] |->
		pm_q[PM_D3] && (|ctl_q[3:0]))
		else $error("wake message outside d3hot or masked");
	AST_GPE: assert property (quiet && gpe_q[0] |-> !msi_req_out[0]
		&& !intx_out[0] && !pme_msg_out[0])
		else $error("pcie signalling in general event mode");
	AST_OE: assert property (quiet |-> gpio7_oe_n_out == !cfg_q[CFG_GPIOALT])
		else $error("gpio7 enable disagrees with alternate mode");
	AST_PIN: assert property (!gpio7_oe_n_out |->
		gpio7_out == general_event_output)
		else $error("gpio7 level differs from general event");
	AST_AUTOOFF: assert property (lat_open_s |-> !slot_power_enable_out[0])
		else $error("slot power on with latch open");
endmodule
`default_nettype wire

/* File: verif/shpc_test.sv */
// bench for the slot hot-plug controller, driven from port one
`timescale 1ns/1ps
`default_nettype none
module shpc_test;
	import shpc_pkg::*;
	localparam logic [2:0] P1 = 3'h1; // port under test
	localparam logic [2:0] SH = 3'h0; // shared registers
	logic core_clk_in, reset_n_in, wr_in, rd_in, eeprom_load_in;
	logic [7:0] addr_in;
	logic [2:0] port_sel_in;
	logic [31:0] wdata_in, rdata_out, rv;
	logic [NUM_PORTS-1:0] attention_button_in, presence_in, power_fault_in;
	logic [NUM_PORTS-1:0] latch_sensor_in, power_good_in, interlock_out;
	logic [NUM_PORTS-1:0] attention_indicator_out, power_indicator_out;
	logic [NUM_PORTS-1:0] slot_power_enable_out, slot_reset_out;
	logic [NUM_PORTS-1:0] msi_req_out, intx_out, pme_msg_out;
	logic general_event_output, gpio7_out, gpio7_oe_n_out;
	int mismatches, comparisons, pcnt;
	// irq table: pm word, control word, expected msi and intx
	logic [31:0] pmv [4] = '{32'h2, 32'h0, 32'h4, 32'h2};
	logic [31:0] ctv [4] = '{32'h3f, 32'h3f, 32'h3f, 32'h1f};
	logic [3:0] emv = 4'h1;
	logic [3:0] eiv = 4'h2;
	shpc_top #(.PME_TIMEOUT(50)) uut (.core_clk_in, .reset_n_in, .addr_in,
		.port_sel_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .eeprom_load_in,
		.attention_button_in, .presence_in, .power_fault_in, .latch_sensor_in,
		.power_good_in, .attention_indicator_out, .power_indicator_out,
		.slot_power_enable_out, .interlock_out, .slot_reset_out, .msi_req_out,
		.intx_out, .pme_msg_out, .general_event_output, .gpio7_out,
		.gpio7_oe_n_out);
	shpc_slot_model mdl (.core_clk_in, .power_enable_in(slot_power_enable_out),
		.button_out(attention_button_in), .presence_out(presence_in),
		.fault_out(power_fault_in), .latch_out(latch_sensor_in),
		.power_good_out(power_good_in));
	// --------
	// clock, wake message counter, bus tasks
	// --------
	initial
	begin
		core_clk_in = 1'b0;
		forever #25 core_clk_in = ~core_clk_in;
	end
	always @(posedge core_clk_in)
		if (pme_msg_out[0] === 1'b1)
			pcnt++;
	task automatic clk(input int n); // ends mid-cycle where outputs settle
		repeat (n) @(posedge core_clk_in);
		@(negedge core_clk_in);
	endtask
	task automatic zero();
		@(negedge core_clk_in);
		pcnt = 0;
		@(posedge core_clk_in); // the pin change that follows lands on the edge
	endtask
	task automatic wr(input logic [2:0] s, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk_in);
		port_sel_in <= s;
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge core_clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] s, input logic [7:0] a);
		@(posedge core_clk_in);
		port_sel_in <= s;
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge core_clk_in);
		rd_in <= 1'b0;
		@(negedge core_clk_in);
		rv = rdata_out;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic done(input string n);
		$display("test %s finished", n);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// --------
	// test sequence
	// --------
	initial
	begin
		{reset_n_in, wr_in, rd_in, eeprom_load_in} = 4'h0;
		{addr_in, port_sel_in, wdata_in} = '0;
		{mismatches, comparisons, pcnt} = '0;
		clk(12);
		@(posedge core_clk_in);
		reset_n_in <= 1'b1;
		mdl.presence_out[0] <= 1'b1; // an unconfigured port ignores it
		clk(6);
		rd(P1, OFS_STS);
		chk("inert status", 32'h0, rv & 32'h1f);
		@(posedge core_clk_in);
		eeprom_load_in <= 1'b1;
		wr(P1, OFS_CAP, 32'h44);
		wr(P1, OFS_CTL, 32'h3f);
		eeprom_load_in <= 1'b0;
		rd(P1, OFS_STS);
		chk("load status", 32'h40, rv & 32'h5f);
		done("load");
		for (int i = 0; i < 4; i++)
		begin
			wr(P1, OFS_PM, pmv[i]);
			wr(P1, OFS_CTL, ctv[i]);
			clk(4);
			chk("msi", 32'(emv[i]), msi_req_out[0]);
			chk("intx", 32'(eiv[i]), intx_out[0]);
			wr(P1, OFS_STS, 32'h10);
			clk(4);
			chk("cleared", 32'h0, msi_req_out[0] | intx_out[0]);
		end
		done("irq");
		wr(P1, OFS_CTL, 32'h3f);
		wr(P1, OFS_STS, 32'h10);
		mdl.presence_out[0] <= 1'b0;
		clk(6);
		rd(P1, OFS_STS);
		chk("removal", 32'h08, rv & 32'h5f);
		chk("removal msi", 32'h1, msi_req_out[0]);
		wr(SH, OFS_CFG, 32'h2);
		clk(6);
		rd(P1, OFS_STS);
		chk("inverted", 32'h40, rv & 32'h40);
		wr(SH, OFS_CFG, 32'h0);
		wr(P1, OFS_STS, 32'h1f);
		done("presence");
		wr(P1, OFS_CTL, 32'h83f);
		clk(1000);
		chk("pulse", 32'h1, interlock_out[0]);
		rd(P1, OFS_STS);
		chk("ilk status", 32'h80, rv & 32'ha0);
		wr(SH, OFS_CFG, 32'h100);
		for (int i = 0; i < 2; i++)
		begin
			wr(P1, OFS_CTL, 32'h83f);
			clk(4);
			chk("toggle", 32'(i), interlock_out[0]);
		end
		wr(SH, OFS_CFG, 32'h300); // latch stands in for interlock state
		for (int i = 0; i < 2; i++)
		begin
			@(posedge core_clk_in);
			mdl.latch_out[0] <= i[0];
			clk(6);
			rd(P1, OFS_STS);
			chk("latch as ilk", 32'(i) << 7, rv & 32'ha0);
		end
		done("interlock");
		wr(SH, OFS_CFG, 32'h400);
		for (int i = 0; i < 2; i++)
		begin
			wr(P1, OFS_CTL, 32'h3f | (32'(i) << 10));
			clk(6);
			chk("auto off", 32'h0, slot_power_enable_out[0]);
		end
		@(posedge core_clk_in);
		mdl.latch_out[0] <= 1'b0; // latch shut: power and indicators come on
		wr(P1, OFS_CTL, 32'h57f);
		clk(12); // supply ramp plus power-good synchroniser
		rv = {29'h0, attention_indicator_out[0], power_indicator_out[0],
			slot_power_enable_out[0]};
		chk("slot outs", 32'h7, rv);
		chk("slot reset", 32'h0, slot_reset_out[0]);
		wr(SH, OFS_CFG, 32'h0);
		wr(P1, OFS_PM, 32'h1);
		wr(P1, OFS_CTL, 32'h08);
		wr(P1, OFS_STS, 32'h1f);
		zero();
		mdl.presence_out[0] <= 1'b1;
		clk(80);
		chk("wake only", 32'h0, intx_out[0]);
		chk("pme count", 32'h2, 32'(pcnt));
		wr(P1, OFS_PM, 32'h9);
		wr(P1, OFS_STS, 32'h1f);
		zero();
		clk(120);
		chk("no resend", 32'h0, 32'(pcnt));
		wr(P1, OFS_CTL, 32'h28);
		zero();
		mdl.presence_out[0] <= 1'b0;
		clk(20);
		chk("wake", 32'h1, 32'(pcnt));
		chk("wake irq", 32'h1, intx_out[0]);
		wr(P1, OFS_PM, 32'h9);
		wr(P1, OFS_STS, 32'h1f);
		wr(P1, OFS_CTL, 32'h30);
		zero();
		mdl.presence_out[0] <= 1'b1;
		clk(20);
		chk("no wake", 32'h0, 32'(pcnt));
		chk("cc irq", 32'h1, intx_out[0]);
		wr(P1, OFS_PM, 32'h8);
		wr(P1, OFS_STS, 32'h1f);
		done("wake");
		wr(P1, OFS_PM, 32'h2);
		wr(P1, OFS_CTL, 32'h28);
		wr(SH, OFS_GPECTL, 32'h1);
		mdl.presence_out[0] <= 1'b0;
		clk(6);
		chk("gpe out", 32'h1, general_event_output);
		chk("gpe msi", 32'h0, msi_req_out[0]);
		chk("pin idle", 32'h1, gpio7_oe_n_out);
		rd(P1, OFS_STS);
		chk("gpe status", 32'h08, rv & 32'h08);
		rd(SH, OFS_GPESTS);
		chk("gpe port", 32'h1, rv & 32'h3f);
		wr(SH, OFS_CFG, 32'h800);
		clk(2);
		chk("pin on", 32'h2, {gpio7_out, gpio7_oe_n_out});
		done("general event");
		@(posedge core_clk_in);
		reset_n_in <= 1'b0;
		clk(2);
		chk("reset ilk", 32'h0, interlock_out[0]);
		chk("reset pin", 32'h1, gpio7_oe_n_out);
		done("reset");
		results();
	end
endmodule
bind shpc_top shpc_chk chk_i (.core_clk_in, .reset_n_in, .addr_in,
	.port_sel_in, .wdata_in, .wr_in, .latch_sensor_in, .slot_power_enable_out,
	.interlock_out, .msi_req_out, .intx_out, .pme_msg_out,
	.general_event_output, .gpio7_out, .gpio7_oe_n_out);
`default_nettype wire
